// ### logic/clk_cfg_regs.sv
// Clock output and main loop configuration bank behind an Avalon-MM slave
//
// Functional notes
// - Aux clock B rate follows the 2-bit code in rate bits 7:6.
// - Aux clock A rate follows the same codes in rate bits 5:4.
// - Aux clock A picks its SONET or SDH rate from family bit 5.
// - A family bit of 1 picks 1544-based rates, 0 2048-based ones.
// - Auto bit 1 uses acquisition bandwidth until lock, 0 never does.
// - Freeze bit 1 holds the loop integral at a limit, 0 never does.
// - While frozen, the reported loop frequency keeps its frozen value.
//
// Our own choice: the Avalon-MM register port.
module clk_cfg_regs
  import clk_cfg_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int FREQ_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic loop_locked_in,
  input wire logic loop_at_limit_in,
  input wire logic [FREQ_W-1:0] loop_freq_in,
  output aux_sel_t aux_clock_a_out,
  output aux_sel_t aux_clock_b_out,
  output logic diff_pecl_en_out,
  output logic diff_lvds_en_out,
  output logic loop_use_acq_bw_out,
  output logic loop_integral_freeze_out,
  output logic [FREQ_W-1:0] loop_freq_report_out
);

  typedef struct packed {
    logic [7:0] family;
    logic [7:0] aux_rate;
    logic [7:0] diff_mode;
    logic [7:0] bw_ctrl;
    logic ack;
    logic [31:0] rdata;
    aux_sel_t aux_a;
    aux_sel_t aux_b;
    logic pecl_en;
    logic lvds_en;
    logic use_acq;
    logic freeze;
    logic [FREQ_W-1:0] freq_rep;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [7:0] word_idx;
  logic req;
  logic [7:0] wbyte;
  logic [7:0] status_byte;
  logic [15:0] freq_wide;
  diff_mode_t diff_code;
  logic [15:0] aux_a_khz;
  logic [15:0] aux_b_khz;

  // Rate lookup, one instance for each auxiliary output
  aux_rate_lookup aux_rate_lookup_b_inst (
    .code_in(st_r.aux_rate[AUX_B_RATE_HI:AUX_B_RATE_LO]),
    .family_in(st_r.family[AUX_B_FAMILY_POS]),
    .khz_out(aux_b_khz)
  );

  aux_rate_lookup aux_rate_lookup_a_inst (
    .code_in(st_r.aux_rate[AUX_A_RATE_HI:AUX_A_RATE_LO]),
    .family_in(st_r.family[AUX_A_FAMILY_POS]),
    .khz_out(aux_a_khz)
  );

  assign word_idx = avs_address_in[9:2];
  assign req = avs_read_in | avs_write_in;
  assign wbyte = avs_writedata_in[7:0];

  // One wait state per access; waitrequest drops in the answer cycle
  assign avs_waitrequest_out = req & ~st_r.ack;

  // Frequency readback is zero-extended or cut to two bytes
  generate
    if (FREQ_W >= 16) begin : g_freq_cut
      assign freq_wide = st_r.freq_rep[15:0];
    end else begin : g_freq_pad
      assign freq_wide = {{(16 - FREQ_W){1'b0}}, st_r.freq_rep};
    end
  endgenerate

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_FREEZE_POS] = st_r.freeze;
    status_byte[STAT_ACQ_POS] = st_r.use_acq;
    status_byte[STAT_LOCKED_POS] = loop_locked_in;
  end

  assign diff_code = diff_mode_t'(st_r.diff_mode[DIFF_MODE_HI:DIFF_MODE_LO]);

  always_comb begin
    st_nxt = st_r;

    // Bus handshake: first cycle fetches, second cycle completes
    st_nxt.ack = 1'b0;
    if (req && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (avs_read_in) begin
        if (word_idx == IDX_FAMILY) begin
          st_nxt.rdata[7:0] = st_r.family;
        end else if (word_idx == IDX_AUX_RATE) begin
          st_nxt.rdata[7:0] = st_r.aux_rate;
        end else if (word_idx == IDX_DIFF_MODE) begin
          st_nxt.rdata[7:0] = st_r.diff_mode;
        end else if (word_idx == IDX_BW_CTRL) begin
          st_nxt.rdata[7:0] = st_r.bw_ctrl;
        end else if (word_idx == IDX_STATUS) begin
          st_nxt.rdata[7:0] = status_byte;
        end else if (word_idx == IDX_FREQ_LO) begin
          st_nxt.rdata[7:0] = freq_wide[7:0];
        end else if (word_idx == IDX_FREQ_HI) begin
          st_nxt.rdata[7:0] = freq_wide[15:8];
        end else begin
          st_nxt.rdata = 32'h0000_0000;
        end
      end
    end

    // Writes land on the edge where waitrequest is low
    if (avs_write_in && st_r.ack && avs_byteenable_in[0]) begin
      if (word_idx == IDX_FAMILY) begin
        st_nxt.family = wbyte;
      end else if (word_idx == IDX_AUX_RATE) begin
        st_nxt.aux_rate = wbyte;
      end else if (word_idx == IDX_DIFF_MODE) begin
        st_nxt.diff_mode = wbyte;
      end else if (word_idx == IDX_BW_CTRL) begin
        st_nxt.bw_ctrl = wbyte;
      end
    end

    // Auxiliary clock selections, registered so outputs never glitch
    st_nxt.aux_b.rate_code =
      st_r.aux_rate[AUX_B_RATE_HI:AUX_B_RATE_LO];
    st_nxt.aux_b.family = st_r.family[AUX_B_FAMILY_POS];
    st_nxt.aux_b.khz = aux_b_khz;
    st_nxt.aux_a.rate_code =
      st_r.aux_rate[AUX_A_RATE_HI:AUX_A_RATE_LO];
    st_nxt.aux_a.family = st_r.family[AUX_A_FAMILY_POS];
    st_nxt.aux_a.khz = aux_a_khz;

    // Spare code 11 keeps the driver off rather than guessing a standard
    st_nxt.pecl_en = (diff_code == DIFF_PECL);
    st_nxt.lvds_en = (diff_code == DIFF_LVDS);

    // Acquisition bandwidth only while auto mode is on and not yet locked
    st_nxt.use_acq =
      st_r.bw_ctrl[AUTO_BW_POS] & ~loop_locked_in;

    st_nxt.freeze =
      st_r.bw_ctrl[FREEZE_EN_POS] & loop_at_limit_in;

    // Report tracks the loop except while frozen
    if (!st_r.freeze) begin
      st_nxt.freq_rep = loop_freq_in;
    end else begin
      st_nxt.freq_rep = st_r.freq_rep;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r.family <= RST_FAMILY;
      st_r.aux_rate <= RST_AUX_RATE;
      st_r.diff_mode <= RST_DIFF_MODE;
      st_r.bw_ctrl <= RST_BW_CTRL;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.aux_a <= '0;
      st_r.aux_b <= '0;
      st_r.pecl_en <= 1'b0;
      st_r.lvds_en <= 1'b0;
      st_r.use_acq <= 1'b0;
      st_r.freeze <= 1'b0;
      st_r.freq_rep <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_out = st_r.rdata;
  assign aux_clock_a_out = st_r.aux_a;
  assign aux_clock_b_out = st_r.aux_b;
  assign diff_pecl_en_out = st_r.pecl_en;
  assign diff_lvds_en_out = st_r.lvds_en;
  assign loop_use_acq_bw_out = st_r.use_acq;
  assign loop_integral_freeze_out = st_r.freeze;
  assign loop_freq_report_out = st_r.freq_rep;

endmodule

// Maps a 2-bit rate code and a family bit to the output rate in kHz
module aux_rate_lookup
  import clk_cfg_pkg::*;
(
  input wire logic [1:0] code_in,
  input wire logic family_in,
  output logic [15:0] khz_out
);

  always_comb begin
    khz_out = 16'h0000;
    if (family_in == FAMILY_SONET) begin
      case (code_in)
        2'b00: khz_out = SONET_KHZ_0;
        2'b01: khz_out = SONET_KHZ_1;
        2'b10: khz_out = SONET_KHZ_2;
        default: khz_out = SONET_KHZ_3;
      endcase
    end else begin
      case (code_in)
        2'b00: khz_out = SDH_KHZ_0;
        2'b01: khz_out = SDH_KHZ_1;
        2'b10: khz_out = SDH_KHZ_2;
        default: khz_out = SDH_KHZ_3;
      endcase
    end
  end

endmodule

// ### logic/clk_cfg_pkg.sv
// Package: register map, field layout and rate tables of the clock config bank
package clk_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FAMILY = 8'h38;
  localparam logic [7:0] IDX_AUX_RATE = 8'h39;
  localparam logic [7:0] IDX_DIFF_MODE = 8'h3a;
  localparam logic [7:0] IDX_BW_CTRL = 8'h3b;
  localparam logic [7:0] IDX_STATUS = 8'h3e;
  localparam logic [7:0] IDX_FREQ_LO = 8'h3f;
  localparam logic [7:0] IDX_FREQ_HI = 8'h40;

  // Reset values
  localparam logic [7:0] RST_FAMILY = 8'h14;
  localparam logic [7:0] RST_AUX_RATE = 8'h08;
  localparam logic [7:0] RST_DIFF_MODE = 8'hc2;
  localparam logic [7:0] RST_BW_CTRL = 8'h98;

  // Field positions
  localparam int AUX_B_RATE_HI = 7;
  localparam int AUX_B_RATE_LO = 6;
  localparam int AUX_A_RATE_HI = 5;
  localparam int AUX_A_RATE_LO = 4;
  localparam int AUX_B_FAMILY_POS = 6;
  localparam int AUX_A_FAMILY_POS = 5;
  localparam int DIFF_MODE_HI = 1;
  localparam int DIFF_MODE_LO = 0;
  localparam int AUTO_BW_POS = 7;
  localparam int FREEZE_EN_POS = 3;
  localparam int STAT_FREEZE_POS = 0;
  localparam int STAT_ACQ_POS = 1;
  localparam int STAT_LOCKED_POS = 2;

  // Family bit: 1 picks the SONET column, 0 the SDH column
  localparam logic FAMILY_SONET = 1'b1;

  typedef enum logic [1:0] {
    DIFF_OFF = 2'b00,
    DIFF_PECL = 2'b01,
    DIFF_LVDS = 2'b10,
    DIFF_SPARE = 2'b11
  } diff_mode_t;

  // Rate tables in kHz, indexed by the 2-bit rate code
  localparam logic [15:0] SONET_KHZ_0 = 16'h0608; // 1544
  localparam logic [15:0] SONET_KHZ_1 = 16'h0c10; // 3088
  localparam logic [15:0] SONET_KHZ_2 = 16'h1820; // 6176
  localparam logic [15:0] SONET_KHZ_3 = 16'h3041; // 12353
  localparam logic [15:0] SDH_KHZ_0 = 16'h0800; // 2048
  localparam logic [15:0] SDH_KHZ_1 = 16'h1000; // 4096
  localparam logic [15:0] SDH_KHZ_2 = 16'h2000; // 8192
  localparam logic [15:0] SDH_KHZ_3 = 16'h4000; // 16384

  typedef struct packed {
    logic [1:0] rate_code;
    logic family;
    logic [15:0] khz;
  } aux_sel_t;

endpackage

// ### tb/clk_cfg_props.sv
// Checker: bus handshake and configuration output properties
module clk_cfg_props
  import clk_cfg_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int FREQ_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic loop_locked_in,
  input wire logic loop_at_limit_in,
  input wire aux_sel_t aux_clock_a_out,
  input wire aux_sel_t aux_clock_b_out,
  input wire logic diff_pecl_en_out,
  input wire logic loop_use_acq_bw_out,
  input wire logic loop_integral_freeze_out,
  input wire logic [FREQ_W-1:0] loop_freq_report_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] idx;
  logic [7:0] wd;
  logic wr;
  assign idx = 8'(avs_address_in >> 2);
  assign wd = avs_writedata_in[7:0];
  // A write lands only at the completing edge with the low lane enabled
  assign wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  AST_WAIT: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  AST_RATE: assert property (wr && idx == IDX_AUX_RATE |->
    ##2 {aux_clock_b_out.rate_code, aux_clock_a_out.rate_code} ==
    $past(wd[7:4], 2)) else $error("rate code");
  AST_FAM: assert property (wr && idx == IDX_FAMILY |->
    ##2 {aux_clock_b_out.family, aux_clock_a_out.family} ==
    $past(wd[6:5], 2)) else $error("family bit");
  AST_KHZ: assert property (
    aux_clock_a_out.rate_code == 2'b11 && aux_clock_a_out.family |->
    aux_clock_a_out.khz == 16'h3041) else $error("top sonet rate");
  AST_PECL: assert property (wr && idx == IDX_DIFF_MODE |->
    ##2 diff_pecl_en_out == ($past(wd[1:0], 2) == 2'b01))
    else $error("pecl");
  AST_ACQ: assert property (loop_locked_in |=>
    !loop_use_acq_bw_out) else $error("acq while locked");
  AST_FRZ: assert property (!loop_at_limit_in |=>
    !loop_integral_freeze_out) else $error("freeze off limit");
  AST_HOLD: assert property (loop_integral_freeze_out |=>
    $stable(loop_freq_report_out)) else $error("report moved");
  cover property (wr && idx == IDX_AUX_RATE);
  cover property ($rose(loop_integral_freeze_out));
  cover property ($rose(loop_use_acq_bw_out));
endmodule

bind clk_cfg_regs clk_cfg_props #(.ADDR_W(ADDR_W), .FREQ_W(FREQ_W))
  clk_cfg_props_inst (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .loop_locked_in(loop_locked_in),
  .loop_at_limit_in(loop_at_limit_in),
  .aux_clock_a_out(aux_clock_a_out),
  .aux_clock_b_out(aux_clock_b_out),
  .diff_pecl_en_out(diff_pecl_en_out),
  .loop_use_acq_bw_out(loop_use_acq_bw_out),
  .loop_integral_freeze_out(loop_integral_freeze_out),
  .loop_freq_report_out(loop_freq_report_out)
);

// ### tb/clock_output_and_dpll_config_tb.sv
// Testbench: register access and output checks of the clock config bank
module clock_output_and_dpll_config_tb
  import clk_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, rd, wr, wreq, lock, lim, pecl, lvds, acq, frz;
  logic [9:0] addr;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [15:0] freq, rep;
  aux_sel_t auxa, auxb;
  int n_fail = 0;
  int check_count = 0;

  clk_cfg_regs clk_cfg_regs_inst (
    .ref_clk_in(clk),
    .rst_in(rst),
    .avs_address_in(addr),
    .avs_read_in(rd),
    .avs_write_in(wr),
    .avs_writedata_in(wdat),
    .avs_byteenable_in(be),
    .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq),
    .loop_locked_in(lock),
    .loop_at_limit_in(lim),
    .loop_freq_in(freq),
    .aux_clock_a_out(auxa),
    .aux_clock_b_out(auxb),
    .diff_pecl_en_out(pecl),
    .diff_lvds_en_out(lvds),
    .loop_use_acq_bw_out(acq),
    .loop_integral_freeze_out(frz),
    .loop_freq_report_out(rep)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [7:0] i,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    addr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wdat <= {24'h0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      summarize();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrt(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, i, d, q);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, i, 8'h00, q);
    chk(q, 32'(e));
  endtask

  // The top SONET rate is not a power-of-two multiple of the base
  function automatic logic [15:0] khz(input logic [1:0] c, input logic s);
    if (s) begin
      return (c == 2'b11) ? 16'h3041 : 16'h0608 << c;
    end
    return 16'h0800 << c;
  endfunction

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdat = '0;
    be = 4'h1;
    lock = 1'b0;
    lim = 1'b0;
    freq = '0;
    tick(4);
    rst <= 1'b0;
    rdc(IDX_FAMILY, 8'h14);
    rdc(IDX_AUX_RATE, 8'h08);
    rdc(IDX_DIFF_MODE, 8'hc2);
    rdc(IDX_BW_CTRL, 8'h98);
    rdc(8'h37, 8'h00);
    chk(32'(auxa), 32'({3'b000, 16'h0800}));
    chk(32'({pecl, lvds}), 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 4; f++) begin
        logic [1:0] cb;
        logic [1:0] ca;
        cb = 2'(c);
        ca = ~cb;
        wrt(IDX_FAMILY, 8'(f << 5));
        wrt(IDX_AUX_RATE, {cb, ca, 4'h0});
        tick(2);
        chk(32'(auxa), 32'({ca, f[0], khz(ca, f[0])}));
        chk(32'(auxb), 32'({cb, f[1], khz(cb, f[1])}));
      end
    end
    for (int m = 0; m < 4; m++) begin
      wrt(IDX_DIFF_MODE, 8'(m + 8'h30));
      tick(2);
      chk(32'({pecl, lvds}), 32'({m == 1, m == 2}));
      rdc(IDX_DIFF_MODE, 8'(m + 8'h30));
    end
    be <= 4'h0;
    wrt(IDX_DIFF_MODE, 8'h01);
    be <= 4'h1;
    rdc(IDX_DIFF_MODE, 8'h33);
    wrt(8'h37, 8'hff);
    rdc(8'h37, 8'h00);
    wrt(IDX_BW_CTRL, 8'h80);
    lim <= 1'b1;
    freq <= 16'h1234;
    tick(2);
    chk(32'({acq, frz, rep}), 32'({2'b10, 16'h1234}));
    lock <= 1'b1;
    tick(2);
    chk(32'({acq, frz, rep}), 32'({2'b00, 16'h1234}));
    wrt(IDX_BW_CTRL, 8'h08);
    lock <= 1'b0;
    lim <= 1'b0;
    tick(2);
    chk(32'({acq, frz, rep}), 32'({2'b00, 16'h1234}));
    lim <= 1'b1;
    freq <= 16'h5678;
    tick(1);
    freq <= 16'h9abc;
    tick(3);
    chk(32'({frz, rep}), 32'({1'b1, 16'h5678}));
    rdc(IDX_STATUS, 8'h01);
    rdc(IDX_FREQ_LO, 8'h78);
    rdc(IDX_FREQ_HI, 8'h56);
    lim <= 1'b0;
    tick(3);
    chk(32'({frz, rep}), 32'({1'b0, 16'h9abc}));
    // Reset in mid-run must bring written registers back to defaults
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdc(IDX_DIFF_MODE, 8'hc2);
    rdc(IDX_BW_CTRL, 8'h98);
    summarize();
  end
endmodule
